// ### hw/fsktx_top.sv
// FSK transmitter digital control: registers, dividers, set select, wake-up
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module fsktx_top
    import fsktx_pkg::*;
#(
    parameter int OSC_WAKE_CYC = OSC_WAKE_CYC_DEF,
    parameter int OSC_QUICK_CYC = OSC_QUICK_CYC_DEF,
    parameter int SYNTH_CYC = SYNTH_CYC_DEF,
    parameter int TX_CYC = TX_CYC_DEF
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_DW-1:0] avs_writedata,
    input wire logic [BUS_BE-1:0] avs_byteenable,
    output logic [BUS_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic data_in,
    input wire logic prescaler_tick,
    output logic band_select_r,
    output logic prescaler_en_r,
    output logic [PWR_W-1:0] pa_level_r,
    output logic osc_en_r,
    output logic osc_boost_r,
    output logic osc_high_bias_r,
    output logic synth_en_r,
    output logic pa_en_r,
    output logic ref_pulse_r,
    output logic fb_pulse_r,
    output logic modulus_high_r,
    output logic active_set_r,
    output logic ref_clock_pin_r
);
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_OSC_WAKE,
        ST_OSC_COUNT,
        ST_STANDBY,
        ST_SYNTH_SETTLE,
        ST_SYNTH,
        ST_TX_WAKE,
        ST_TX
    } fsktx_state_e;

    fsktx_state_e state_r;
    fsktx_ctrl_s ctrl_r;
    fsktx_divset_s set0_r;
    fsktx_divset_s set1_r;
    fsktx_divset_s act_r;
    fsktx_stat_s stat;
    logic presc_r;
    logic wait_r;
    logic [BUS_DW-1:0] rdata_r;
    logic [BUS_DW-1:0] rd_mux;
    logic [BUS_DW-1:0] wr_merged;
    logic req;
    logic wr_take;
    logic [TMR_W-1:0] tmr_r;
    logic [1:0] pulse_cnt_r;
    logic [REF_W-1:0] ref_cnt_r;
    logic [MAIN_W-1:0] main_cnt_r;
    logic [AUX_W-1:0] aux_cnt_r;
    logic [REF_CLOCK_PIN_W-1:0] clk_div_r;
    logic ref_run;
    logic quick;
    logic use_set1;

    function automatic logic [BUS_DW-1:0] merge_bytes(
        input logic [BUS_DW-1:0] old_v,
        input logic [BUS_DW-1:0] new_v,
        input logic [BUS_BE-1:0] be
    );
        logic [BUS_DW-1:0] res;
        res = old_v;
        for (int i = 0; i < BUS_BE; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Avalon slave: one wait cycle, then the access completes
    assign req = avs_read | avs_write;
    assign wr_take = avs_write & ~wait_r;
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    always_comb begin
        stat = '0;
        stat.tx_ready = (state_r == ST_TX);
        stat.synth_ready = (state_r == ST_SYNTH) || (state_r == ST_TX_WAKE)
            || (state_r == ST_TX);
        stat.osc_ready = (state_r != ST_SLEEP) && (state_r != ST_OSC_WAKE)
            && (state_r != ST_OSC_COUNT);
        stat.osc_boost_on = osc_boost_r;
        stat.active_set = active_set_r;
    end

    always_comb begin
        rd_mux = '0;
        unique case (avs_address)
            OFF_CTRL: rd_mux[$bits(fsktx_ctrl_s)-1:0] = ctrl_r;
            OFF_SET0: rd_mux[$bits(fsktx_divset_s)-1:0] = set0_r;
            OFF_SET1: rd_mux[$bits(fsktx_divset_s)-1:0] = set1_r;
            OFF_STAT: rd_mux[$bits(fsktx_stat_s)-1:0] = stat;
            OFF_PRESC: rd_mux[PRESC_BIT] = presc_r;
            default: rd_mux = '0;
        endcase
    end

    assign wr_merged = merge_bytes(rd_mux, avs_writedata, avs_byteenable);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else if (req && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (avs_read && wait_r) begin
            rdata_r <= rd_mux;
        end
    end

    // register writes on the accepting edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST;
            set0_r <= SET_RST;
            set1_r <= SET_RST;
            presc_r <= PRESC_RST;
        end else if (wr_take) begin
            if (avs_address == OFF_CTRL) begin
                ctrl_r <= wr_merged[$bits(fsktx_ctrl_s)-1:0];
            end
            if (avs_address == OFF_SET0) begin
                set0_r <= wr_merged[$bits(fsktx_divset_s)-1:0];
            end
            if (avs_address == OFF_SET1) begin
                set1_r <= wr_merged[$bits(fsktx_divset_s)-1:0];
            end
            if (avs_address == OFF_PRESC) begin
                presc_r <= wr_merged[PRESC_BIT];
            end
        end
    end

    // boost on with high bias off takes the quick wake time
    assign quick = ctrl_r.osc_boost_start & ~ctrl_r.osc_high_bias;

    // Power sequencing; a sleep request overrides every state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_SLEEP;
            tmr_r <= '0;
        end else if (ctrl_r.op_mode == OPM_SLEEP) begin
            state_r <= ST_SLEEP;
        end else begin
            unique case (state_r)
                ST_SLEEP: begin
                    state_r <= ST_OSC_WAKE;
                    tmr_r <= quick ? TMR_W'(OSC_QUICK_CYC - 1) : TMR_W'(OSC_WAKE_CYC - 1);
                end
                ST_OSC_WAKE: begin
                    if (tmr_r == '0) begin
                        state_r <= ST_OSC_COUNT;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_OSC_COUNT: begin
                    if (ref_pulse_r && (pulse_cnt_r == OSC_FIRST_PULSES - 2'h1)) begin
                        state_r <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (ctrl_r.op_mode != OPM_STANDBY) begin
                        state_r <= ST_SYNTH_SETTLE;
                        tmr_r <= TMR_W'(SYNTH_CYC - 1);
                    end
                end
                ST_SYNTH_SETTLE: begin
                    if (ctrl_r.op_mode == OPM_STANDBY) begin
                        state_r <= ST_STANDBY;
                    end else if (tmr_r == '0) begin
                        state_r <= ST_SYNTH;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_SYNTH: begin
                    if (ctrl_r.op_mode == OPM_STANDBY) begin
                        state_r <= ST_STANDBY;
                    end else if (ctrl_r.op_mode == OPM_TX) begin
                        state_r <= ST_TX_WAKE;
                        tmr_r <= TMR_W'(TX_CYC - 1);
                    end
                end
                ST_TX_WAKE: begin
                    if (ctrl_r.op_mode != OPM_TX) begin
                        state_r <= ST_SYNTH;
                    end else if (tmr_r == '0) begin
                        state_r <= ST_TX;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_TX: begin
                    if (ctrl_r.op_mode != OPM_TX) begin
                        state_r <= ST_SYNTH;
                    end
                end
            endcase
        end
    end

    // Reference pulses seen during oscillator qualification
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt_r <= '0;
        end else if (state_r != ST_OSC_COUNT) begin
            pulse_cnt_r <= '0;
        end else if (ref_pulse_r) begin
            pulse_cnt_r <= pulse_cnt_r + 2'h1;
        end
    end

    // boost current ends at first reference pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_boost_r <= 1'b0;
        end else if (state_r == ST_SLEEP) begin
            osc_boost_r <= (ctrl_r.op_mode != OPM_SLEEP) & ctrl_r.osc_boost_start;
        end else if (ref_pulse_r) begin
            osc_boost_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_en_r <= 1'b0;
            synth_en_r <= 1'b0;
            pa_en_r <= 1'b0;
            osc_high_bias_r <= 1'b0;
            band_select_r <= 1'b0;
            prescaler_en_r <= 1'b0;
            pa_level_r <= '0;
        end else begin
            osc_en_r <= (state_r != ST_SLEEP);
            synth_en_r <= (state_r == ST_SYNTH_SETTLE) || (state_r == ST_SYNTH)
                || (state_r == ST_TX_WAKE) || (state_r == ST_TX);
            pa_en_r <= (state_r == ST_TX_WAKE) || (state_r == ST_TX);
            osc_high_bias_r <= ctrl_r.osc_high_bias;
            // band drives VCO post-divider (0: by 4, 1: by 2)
            band_select_r <= ctrl_r.band_select;
            prescaler_en_r <= presc_r;
            // eight power steps, 7 is highest
            pa_level_r <= ctrl_r.power;
        end
    end

    // outside divider mode only set 0; 11 treated as set 0
    // in divider mode the data bit picks the set
    assign use_set1 = ({ctrl_r.mod_mode_upper, ctrl_r.mod_mode_lower} == MOD_DIVIDER)
        & data_in;

    // both sets in divider mode; set 0 for zero, set 1 for one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            act_r <= SET_RST;
            active_set_r <= 1'b0;
        end else begin
            act_r <= use_set1 ? set1_r : set0_r;
            active_set_r <= use_set1;
        end
    end

    assign ref_run = (state_r != ST_SLEEP) && (state_r != ST_OSC_WAKE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_r <= '0;
            ref_pulse_r <= 1'b0;
        end else if (!ref_run) begin
            ref_cnt_r <= '0;
            ref_pulse_r <= 1'b0;
        end else if (ref_cnt_r >= REF_W'(act_r.ref_div - 1'b1)) begin
            ref_cnt_r <= '0;
            ref_pulse_r <= 1'b1;
        end else begin
            ref_cnt_r <= ref_cnt_r + 1'b1;
            ref_pulse_r <= 1'b0;
        end
    end

    // 12-bit main and 6-bit aux feedback counters
    // dual-modulus 16/17 gives 16N+A per feedback pulse
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            main_cnt_r <= '0;
            aux_cnt_r <= '0;
            fb_pulse_r <= 1'b0;
        end else if (!(synth_en_r && presc_r)) begin
            main_cnt_r <= '0;
            aux_cnt_r <= '0;
            fb_pulse_r <= 1'b0;
        end else if (prescaler_tick) begin
            if (main_cnt_r >= MAIN_W'(act_r.main - 1'b1)) begin
                main_cnt_r <= '0;
                aux_cnt_r <= '0;
                fb_pulse_r <= 1'b1;
            end else begin
                main_cnt_r <= main_cnt_r + 1'b1;
                fb_pulse_r <= 1'b0;
                if (aux_cnt_r < act_r.aux) begin
                    aux_cnt_r <= aux_cnt_r + 1'b1;
                end
            end
        end else begin
            fb_pulse_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            modulus_high_r <= 1'b0;
        end else begin
            modulus_high_r <= synth_en_r && presc_r && (aux_cnt_r < act_r.aux);
        end
    end

    // reference clock out; clock over 16, low when off or asleep
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_div_r <= '0;
            ref_clock_pin_r <= 1'b0;
        end else if (ctrl_r.ref_clock_out_enable && (state_r != ST_SLEEP)) begin
            clk_div_r <= clk_div_r + 1'b1;
            ref_clock_pin_r <= clk_div_r[REF_CLOCK_PIN_W-1];
        end else begin
            clk_div_r <= '0;
            ref_clock_pin_r <= 1'b0;
        end
    end
endmodule

// ### hw/fsktx_pkg.sv
// Constants, types and register map of the FSK transmitter control block
package fsktx_pkg;
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam int BUS_BE = BUS_DW / 8;

    localparam logic [BUS_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [BUS_AW-1:0] OFF_SET0 = 8'h04;
    localparam logic [BUS_AW-1:0] OFF_SET1 = 8'h08;
    localparam logic [BUS_AW-1:0] OFF_STAT = 8'h0c;
    localparam logic [BUS_AW-1:0] OFF_PRESC = 8'h10;
    localparam int PRESC_BIT = 4;

    localparam int REF_W = 12;
    localparam int MAIN_W = 12;
    localparam int AUX_W = 6;
    localparam int PWR_W = 3;

    // Operating mode requested by software
    localparam logic [1:0] OPM_SLEEP = 2'h0;
    localparam logic [1:0] OPM_STANDBY = 2'h1;
    localparam logic [1:0] OPM_SYNTH = 2'h2;
    localparam logic [1:0] OPM_TX = 2'h3;

    // Modulation mode field {upper, lower}
    localparam logic [1:0] MOD_CLOSED_LOOP_VCO = 2'h0;
    localparam logic [1:0] MOD_OPEN_LOOP_VCO = 2'h1;
    localparam logic [1:0] MOD_DIVIDER = 2'h2;
    localparam logic [1:0] MOD_UNUSED = 2'h3;

    localparam int REF_CLOCK_PIN_DIV = 16;
    localparam int REF_CLOCK_PIN_W = $clog2(REF_CLOCK_PIN_DIV);
    localparam logic [1:0] OSC_FIRST_PULSES = 2'h2;

    // Timing, figures in their own units
    localparam real CLK_PERIOD_NS = 8.0;
    localparam real OSC_WAKE_MS = 0.8;
    localparam real OSC_QUICK_MS = 0.15;
    localparam real SYNTH_SETTLE_MS = 2.0;
    localparam real TX_WAKE_US = 500.0;
    localparam int OSC_WAKE_CYC_DEF = int'($floor(OSC_WAKE_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int OSC_QUICK_CYC_DEF = int'($floor(OSC_QUICK_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int SYNTH_CYC_DEF = int'($floor(SYNTH_SETTLE_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int TX_CYC_DEF = int'($floor(TX_WAKE_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int TMR_W = 18;

    typedef struct packed {
        logic [AUX_W-1:0] aux;
        logic [MAIN_W-1:0] main;
        logic [REF_W-1:0] ref_div;
    } fsktx_divset_s;

    typedef struct packed {
        logic [1:0] op_mode;
        logic ref_clock_out_enable;
        logic osc_high_bias;
        logic osc_boost_start;
        logic [PWR_W-1:0] power;
        logic mod_mode_upper;
        logic mod_mode_lower;
        logic band_select;
    } fsktx_ctrl_s;

    typedef struct packed {
        logic tx_ready;
        logic synth_ready;
        logic osc_ready;
        logic osc_boost_on;
        logic active_set;
    } fsktx_stat_s;

    localparam fsktx_ctrl_s CTRL_RST = '0;
    localparam fsktx_divset_s SET_RST = '0;
    localparam logic PRESC_RST = 1'b0;
endpackage

// ### sim/fsktx_top_assertions.sv
// Concurrent checks on the FSK transmitter control ports
`timescale 1ns/10ps
module fsktx_top_assertions
    import fsktx_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [BUS_DW-1:0] avs_writedata,
    input wire logic [BUS_BE-1:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic data_in,
    input wire logic osc_en_r,
    input wire logic osc_boost_r,
    input wire logic synth_en_r,
    input wire logic pa_en_r,
    input wire logic ref_pulse_r,
    input wire logic active_set_r,
    input wire logic ref_clock_pin_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [1:0] mode_r;
    logic ctrl_wr;
    assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == OFF_CTRL;
    // Mirror of the modulation field
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 2'h0;
        end else if (ctrl_wr && avs_byteenable[0]) begin
            mode_r <= avs_writedata[2:1];
        end
    end
    sequence s_request;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_asleep;
        !osc_en_r [*3];
    endsequence
    a_wait_answer: assert property (s_request |=> !avs_waitrequest)
        else $error("bus access not answered after one wait cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_set_follows_data: assert property ($past(mode_r) == MOD_DIVIDER |->
        active_set_r == $past(data_in)) else $error("divider set does not follow data");
    a_set0_only: assert property ($past(mode_r) != MOD_DIVIDER |-> !active_set_r)
        else $error("set 1 applied outside divider mode");
    a_clk_asleep: assert property (s_asleep |-> !ref_clock_pin_r)
        else $error("clock pin not low in sleep");
    a_clk_low_half: assert property ($fell(ref_clock_pin_r) |-> !ref_clock_pin_r [*8])
        else $error("clock pin low half shorter than 8 cycles");
    a_pa_after_synth: assert property (pa_en_r |-> synth_en_r)
        else $error("amplifier on without synthesizer");
    a_synth_after_osc: assert property (synth_en_r |-> osc_en_r)
        else $error("synthesizer on without oscillator");
    a_boost_drop: assert property (osc_boost_r && ref_pulse_r |-> ##[1:2] !osc_boost_r)
        else $error("boost not cleared by reference pulse");
endmodule
bind fsktx_top fsktx_top_assertions fsktx_chk_inst (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .data_in(data_in), .osc_en_r(osc_en_r),
    .osc_boost_r(osc_boost_r), .synth_en_r(synth_en_r), .pa_en_r(pa_en_r),
    .ref_pulse_r(ref_pulse_r), .active_set_r(active_set_r),
    .ref_clock_pin_r(ref_clock_pin_r));

// ### sim/fsktx_host_model.sv
// Far-side stand-in: data bit source and prescaler output ticks
`timescale 1ns/10ps
module fsktx_host_model #(
    parameter int TICK_DIV = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic bit_req,
    output logic data_in,
    output logic prescaler_tick
);
    logic [3:0] cnt_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_in <= 1'b0;
        end else begin
            data_in <= bit_req;
        end
    end
    // One tick per prescaler period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            prescaler_tick <= 1'b0;
        end else begin
            cnt_r <= (cnt_r == 4'(TICK_DIV - 1)) ? 4'h0 : cnt_r + 4'h1;
            prescaler_tick <= (cnt_r == 4'h0);
        end
    end
endmodule

// ### sim/fsktx_top_test.sv
// Register-level regression of the FSK transmitter control block
`timescale 1ns/10ps
module fsktx_top_test
    import fsktx_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [BUS_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [BUS_DW-1:0] avs_writedata = '0;
    logic [BUS_BE-1:0] avs_byteenable = 4'hf;
    logic bit_req = 1'b0;
    logic [BUS_DW-1:0] avs_readdata, rd;
    logic [PWR_W-1:0] pa_level_r;
    logic avs_waitrequest, data_in, prescaler_tick, band_select_r, prescaler_en_r;
    logic osc_en_r, osc_boost_r, osc_high_bias_r, synth_en_r, pa_en_r, ref_pulse_r;
    logic fb_pulse_r, modulus_high_r, active_set_r, ref_clock_pin_r, pin_q;
    int miscompares = 0;
    int cmp_count = 0;
    int n1, n2, gap;
    always #4 clock = ~clock;
    always @(posedge clock) pin_q <= ref_clock_pin_r;
    fsktx_top #(.OSC_WAKE_CYC(8), .OSC_QUICK_CYC(4), .SYNTH_CYC(10), .TX_CYC(6)) fsktx_top_inst (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .data_in(data_in),
        .prescaler_tick(prescaler_tick), .band_select_r(band_select_r),
        .prescaler_en_r(prescaler_en_r), .pa_level_r(pa_level_r), .osc_en_r(osc_en_r),
        .osc_boost_r(osc_boost_r), .osc_high_bias_r(osc_high_bias_r), .synth_en_r(synth_en_r),
        .pa_en_r(pa_en_r), .ref_pulse_r(ref_pulse_r), .fb_pulse_r(fb_pulse_r),
        .modulus_high_r(modulus_high_r), .active_set_r(active_set_r),
        .ref_clock_pin_r(ref_clock_pin_r));
    fsktx_host_model #(.TICK_DIV(3)) fsktx_host_model_inst (.clock(clock), .rst_n(rst_n),
        .bit_req(bit_req), .data_in(data_in), .prescaler_tick(prescaler_tick));
    task automatic chk(input string name, input logic [BUS_DW-1:0] exp,
            input logic [BUS_DW-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [BUS_AW-1:0] a,
            input logic [BUS_DW-1:0] d, output logic [BUS_DW-1:0] q);
        int n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            chk("bus answer", 0, 1);
            test_done();
        end
    endtask
    task automatic wr(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
        logic [BUS_DW-1:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input string name, input logic [BUS_AW-1:0] a,
            input logic [BUS_DW-1:0] exp);
        bus(1'b0, a, '0, rd);
        chk(name, exp, rd);
    endtask
    // Polls a status bit until it sets
    task automatic poll(input int b, output int n);
        n = 0;
        do begin
            bus(1'b0, OFF_STAT, '0, rd);
            n++;
        end while (rd[b] !== 1'b1 && n < 50);
        chk("status bit set", 1, rd[b]);
        if (rd[b] !== 1'b1) begin
            test_done();
        end
    endtask
    // Cycles between two events: 0 ref pulse, 1 pin rise, 2 feedback pulse
    task automatic gap_of(input int sel, output int g);
        int k, t0;
        logic ev;
        t0 = -1;
        g = -1;
        for (k = 0; k < 100 && g < 0; k++) begin
            @(posedge clock);
            ev = (sel == 0) ? ref_pulse_r : (sel == 1) ? (ref_clock_pin_r && !pin_q) : fb_pulse_r;
            if (ev === 1'b1) begin
                if (t0 >= 0) g = k - t0;
                t0 = k;
            end
        end
        if (g < 0) begin
            chk("event gap seen", 1, 0);
            test_done();
        end
    endtask
    task automatic pin_low(input int n);
        // Pin follows the write one edge late
        @(posedge clock);
        repeat (n) begin
            @(posedge clock);
            chk("clock pin off", 0, ref_clock_pin_r);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        chk("run time", 0, 1);
        test_done();
    end
    initial begin
        repeat (3) @(posedge clock);
        chk("waitrequest in reset", 1, avs_waitrequest);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk("reset value", 8'(i * 4), '0);
        wr(OFF_SET0, 32'hffff_f001);
        rdchk("set0 widths", OFF_SET0, 32'h3fff_f001);
        wr(OFF_SET1, 32'hc0ab_cdef);
        rdchk("set1 widths", OFF_SET1, 32'h00ab_cdef);
        wr(OFF_STAT, 32'h0000_00ff);
        rdchk("status read only", OFF_STAT, '0);
        wr(8'h14, 32'h0000_005a);
        rdchk("unmapped", 8'h14, '0);
        wr(OFF_PRESC, 32'h0000_00ff);
        rdchk("prescaler on", OFF_PRESC, 32'h0000_0010);
        chk("prescaler pin on", 1, prescaler_en_r);
        wr(OFF_PRESC, 32'h0000_00ef);
        rdchk("prescaler off", OFF_PRESC, '0);
        chk("prescaler pin off", 0, prescaler_en_r);
        $display("Test registers done");
        for (int p = 0; p < 8; p++) begin
            wr(OFF_CTRL, 32'(p * 8 + (p % 2) * 129));
            repeat (2) @(posedge clock);
            chk("power step", 32'(p), pa_level_r);
            chk("band", 32'(p % 2), band_select_r);
            chk("high bias", 32'(p % 2), osc_high_bias_r);
        end
        $display("Test band and power done");
        for (int m = 0; m < 4; m++) begin
            wr(OFF_CTRL, 32'(m * 2));
            bit_req <= 1'b1;
            repeat (3) @(posedge clock);
            chk("set on data one", 32'(m == 2), active_set_r);
            rdchk("status set", OFF_STAT, 32'(m == 2));
            bit_req <= 1'b0;
            repeat (3) @(posedge clock);
            chk("set on data zero", 0, active_set_r);
        end
        $display("Test modulation modes done");
        wr(OFF_SET0, 32'h0100_2003);
        wr(OFF_PRESC, 32'h0000_0010);
        wr(OFF_CTRL, 32'h0000_0300);
        poll(2, n1);
        wr(OFF_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clock);
        wr(OFF_CTRL, 32'h0000_0340);
        poll(2, n2);
        chk("quick wake shorter", 1, n2 < n1);
        chk("boost cleared", 0, rd[1]);
        gap_of(0, gap);
        chk("reference period", 3, gap);
        gap_of(1, gap);
        chk("clock pin period", 16, gap);
        $display("Test oscillator wake done");
        wr(OFF_CTRL, 32'h0000_0540);
        poll(3, n1);
        chk("synth enable", 1, synth_en_r);
        gap_of(2, gap);
        chk("feedback period", 6, gap);
        // Aux count of one holds the high modulus for one tick period
        n2 = 0;
        repeat (6) begin
            @(posedge clock);
            n2 += int'(modulus_high_r);
        end
        chk("high modulus cycles", 3, n2);
        wr(OFF_CTRL, 32'h0000_0740);
        poll(4, n1);
        chk("amplifier enable", 1, pa_en_r);
        wr(OFF_CTRL, 32'h0000_0640);
        pin_low(20);
        wr(OFF_CTRL, 32'h0000_0100);
        repeat (3) @(posedge clock);
        chk("oscillator off", 0, osc_en_r);
        chk("amplifier off", 0, pa_en_r);
        pin_low(20);
        $display("Test power sequence done");
        test_done();
    end
endmodule
